// ===== pwmi_pkg.sv
/*
  Constants and types of the PWM interrupt status and clear block.
  Assumes a 32-bit APB slave port and single-cycle event pulses from the
  timers, operators, trip logic and capture units, all on the same clock.
*/
// Notes on behaviour
// R01: Masked status bit per source, read only.
// R02: Clear register at 0x11C, write one clears.
// R03: Three capture channels, own status and clear.
// R04: One-shot trip per output pair, three bits.
// R05: Cycle-by-cycle trip per output pair, three bits.
// R06: Compare A and B per operator, separate bits.
// R07: Fault start and end raise distinct flags.
// R08: Timer zero and period flags per timer.
// R09: Timer stop flag per timer.
// R10: Raw flags at 0x114 set regardless of enable.
// R11: Enable register at 0x110 gates masked status.
// R12: Masked is raw AND enable; interrupt ORs masked.
// R13: Writing zero clears nothing; clear reads zero.
`default_nettype none

package pwmi_pkg;

  localparam int PWMI_ADDR_W = 12;
  localparam int PWMI_DATA_W = 32;
  localparam int PWMI_NUM_SRC = 30;
  localparam int PWMI_GRP_W = 3;

  // Register byte offsets
  localparam logic [PWMI_ADDR_W-1:0] PWMI_ENABLE_OFS = 12'h110;
  localparam logic [PWMI_ADDR_W-1:0] PWMI_RAW_OFS = 12'h114;
  localparam logic [PWMI_ADDR_W-1:0] PWMI_MASKED_OFS = 12'h118;
  localparam logic [PWMI_ADDR_W-1:0] PWMI_CLEAR_OFS = 12'h11C;

  // Lowest bit of each group of three sources
  localparam int PWMI_TIMER_STOP_LSB = 0;
  localparam int PWMI_TIMER_ZERO_LSB = 3;
  localparam int PWMI_TIMER_PERIOD_LSB = 6;
  localparam int PWMI_FAULT_START_LSB = 9;
  localparam int PWMI_FAULT_END_LSB = 12;
  localparam int PWMI_COMPARE_A_LSB = 15;
  localparam int PWMI_COMPARE_B_LSB = 18;
  localparam int PWMI_CYCLE_TRIP_LSB = 21;
  localparam int PWMI_ONE_SHOT_LSB = 24;
  localparam int PWMI_CAPTURE_LSB = 27;

  // Reset values
  localparam logic [PWMI_NUM_SRC-1:0] PWMI_ENABLE_RST = 30'h0;
  localparam logic [PWMI_NUM_SRC-1:0] PWMI_RAW_RST = 30'h0;

  typedef struct packed {
    logic [PWMI_NUM_SRC-1:0] enable;
    logic [PWMI_GRP_W-1:0] fault_prev;
    logic ready;
    logic [PWMI_DATA_W-1:0] rdata;
    logic slverr;
    logic irq;
  } pwmi_regs_s;

  localparam pwmi_regs_s PWMI_REGS_RST = '{
    enable: PWMI_ENABLE_RST,
    fault_prev: 3'h0,
    ready: 1'b0,
    rdata: 32'h0,
    slverr: 1'b0,
    irq: 1'b0
  };

  typedef struct packed {
    logic [PWMI_NUM_SRC-1:0] raw;
  } pwmi_bank_s;

endpackage

`default_nettype wire

// ===== pwmi_flag_if.sv
/*
  Connection between the register front end and the raw flag bank.
  Assumes both ends run on the same peripheral clock.
*/
`default_nettype none

interface pwmi_flag_if #(parameter int N = 30);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] raw;
  modport bank (input set, input clr, output raw);
  modport ctrl (output set, output clr, input raw);
endinterface

`default_nettype wire

// ===== pwmi_flag_bank.sv
/*
  Sticky raw interrupt flags, one per source.
  Assumes set and clr are single-cycle terms on the same clock.
*/
`default_nettype none

module pwmi_flag_bank
  import pwmi_pkg::*;
#(
  parameter int N = PWMI_NUM_SRC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flag set, clear and state
  pwmi_flag_if.bank flags
);

  pwmi_bank_s r;
  pwmi_bank_s next_r;
  logic [N-1:0] next_bit;

  ////////////////////////////////////////////////////////////////////
  // A flag is set by its event whatever its enable says; an event in
  // the clearing cycle survives so no edge is lost
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      assign next_bit[i] = flags.set[i] | (r.raw[i] & ~flags.clr[i]); // [R10] [R02]
    end
  endgenerate

  always_comb begin
    next_r = r;
    next_r.raw = next_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{raw: PWMI_RAW_RST};
    end else begin
      r <= next_r;
    end
  end

  assign flags.raw = r.raw;

endmodule

`default_nettype wire

// ===== pwmi_irq_ctrl.sv
/*
  Interrupt status, enable and clear registers of a three-timer,
  three-operator PWM unit, reached over APB.
  Assumes all event inputs are one-cycle pulses, and fault inputs are
  levels, all from logic clocked by pclk.
*/
// Decided for this implementation: the APB slave port.
`default_nettype none

module pwmi_irq_ctrl
  import pwmi_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PWMI_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PWMI_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [PWMI_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture and trip events
  input wire logic [PWMI_GRP_W-1:0] capture_event,
  input wire logic [PWMI_GRP_W-1:0] one_shot_trip,
  input wire logic [PWMI_GRP_W-1:0] cycle_by_cycle_trip,
  // Operator events
  input wire logic [PWMI_GRP_W-1:0] operator_compare_a_event,
  input wire logic [PWMI_GRP_W-1:0] operator_compare_b_event,
  // Fault levels
  input wire logic fault_event_0,
  input wire logic fault_event_1,
  input wire logic fault_event_2,
  // Timer events
  input wire logic [PWMI_GRP_W-1:0] timer_period_event,
  input wire logic [PWMI_GRP_W-1:0] timer_zero_event,
  input wire logic [PWMI_GRP_W-1:0] timer_stop_event,
  // Interrupt
  output logic pwm_irq
);

  pwmi_regs_s r;
  pwmi_regs_s next_r;
  pwmi_flag_if #(.N(PWMI_NUM_SRC)) flags ();

  pwmi_flag_bank #(.N(PWMI_NUM_SRC)) u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////////
  // Byte lanes of a write

  function automatic logic [PWMI_DATA_W-1:0] lane_mask(input logic [3:0] strb);
    logic [PWMI_DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next state

  logic [PWMI_GRP_W-1:0] fault_now;
  logic setup;
  logic done;
  logic [PWMI_DATA_W-1:0] lmask;
  logic [PWMI_DATA_W-1:0] wmask;
  logic [PWMI_NUM_SRC-1:0] set_v;
  logic [PWMI_NUM_SRC-1:0] clr_v;
  logic [PWMI_NUM_SRC-1:0] masked;
  logic [PWMI_NUM_SRC-1:0] raw_ahead;

  always_comb begin
    next_r = r;
    fault_now = {fault_event_2, fault_event_1, fault_event_0};
    setup = psel & ~penable;
    done = psel & penable & r.ready;
    lmask = lane_mask(pstrb);
    wmask = pwdata & lmask;
    masked = flags.raw & r.enable; // [R01] [R12]

    // Event vector, one group of three per source kind
    set_v = '0;
    set_v[PWMI_TIMER_STOP_LSB +: PWMI_GRP_W] = timer_stop_event; // [R09]
    set_v[PWMI_TIMER_ZERO_LSB +: PWMI_GRP_W] = timer_zero_event; // [R08]
    set_v[PWMI_TIMER_PERIOD_LSB +: PWMI_GRP_W] = timer_period_event; // [R08]
    set_v[PWMI_FAULT_START_LSB +: PWMI_GRP_W] = fault_now & ~r.fault_prev; // [R07]
    set_v[PWMI_FAULT_END_LSB +: PWMI_GRP_W] = ~fault_now & r.fault_prev; // [R07]
    set_v[PWMI_COMPARE_A_LSB +: PWMI_GRP_W] = operator_compare_a_event; // [R06]
    set_v[PWMI_COMPARE_B_LSB +: PWMI_GRP_W] = operator_compare_b_event; // [R06]
    set_v[PWMI_CYCLE_TRIP_LSB +: PWMI_GRP_W] = cycle_by_cycle_trip; // [R05]
    set_v[PWMI_ONE_SHOT_LSB +: PWMI_GRP_W] = one_shot_trip; // [R04]
    set_v[PWMI_CAPTURE_LSB +: PWMI_GRP_W] = capture_event; // [R03]
    next_r.fault_prev = fault_now;

    // Only ones written at the completing edge clear anything
    clr_v = '0;
    if (done && pwrite && paddr == PWMI_CLEAR_OFS) begin
      clr_v = wmask[PWMI_NUM_SRC-1:0]; // [R02] [R13]
    end

    if (done && pwrite && paddr == PWMI_ENABLE_OFS) begin
      next_r.enable = (r.enable & ~lmask[PWMI_NUM_SRC-1:0])
                    | wmask[PWMI_NUM_SRC-1:0]; // [R11]
    end

    // Read data is sampled in the setup cycle and held; one wait-free access
    next_r.ready = setup;
    if (setup) begin
      next_r.slverr = 1'b0;
      next_r.rdata = '0;
      unique case (paddr)
        PWMI_ENABLE_OFS: next_r.rdata[PWMI_NUM_SRC-1:0] = r.enable; // [R11]
        PWMI_RAW_OFS: next_r.rdata[PWMI_NUM_SRC-1:0] = flags.raw; // [R10]
        PWMI_MASKED_OFS: next_r.rdata[PWMI_NUM_SRC-1:0] = masked; // [R01]
        PWMI_CLEAR_OFS: next_r.rdata = '0; // [R13]
        default: next_r.slverr = 1'b1;
      endcase
    end else begin
      // Answer stands one cycle even if a master drops a transfer early
      next_r.slverr = 1'b0;
      next_r.rdata = '0;
    end

    // Interrupt tracks the flags as they will stand after this edge
    raw_ahead = set_v | (flags.raw & ~clr_v);
    next_r.irq = |(raw_ahead & next_r.enable); // [R12]

    flags.set = set_v;
    flags.clr = clr_v;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= PWMI_REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;
  assign pwm_irq = r.irq;

endmodule

`default_nettype wire

// ===== pwmi_irq_ctrl_asserts.sv
/* Protocol and masking checks for the PWM interrupt block.
   Sees only the top ports; bound from the bench top file. */
`default_nettype none
module pwmi_irq_ctrl_asserts
  import pwmi_pkg::*;
(
  // Watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PWMI_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PWMI_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [PWMI_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  logic mapped;
  assign mapped = paddr inside {PWMI_ENABLE_OFS, PWMI_RAW_OFS, PWMI_MASKED_OFS, PWMI_CLEAR_OFS};
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence done_s;
    pready && psel && penable;
  endsequence
  // Enable cleared in full: nothing may still drive the line
  sequence en_off_s;
    done_s ##0 (pwrite && paddr == PWMI_ENABLE_OFS && pwdata == 32'h0 && pstrb == 4'hF);
  endsequence
  // Masked read: the word sampled at setup is nonzero exactly when irq stood
  sequence rd_masked_s;
    setup_s ##0 (!pwrite && paddr == PWMI_MASKED_OFS);
  endsequence
  ////////////////////////////////////////
  chk_ready_once: assert property (setup_s |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  chk_ready_cause: assert property (pready |-> $past(psel && !penable) && psel && penable)
    else $error("ready without a setup");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_clear_zero: assert property (
      done_s ##0 (!pwrite && paddr == PWMI_CLEAR_OFS) |-> prdata == 32'h0)
    else $error("clear register read not zero");
  chk_irq_masked: assert property (rd_masked_s |=> (prdata != 32'h0) == $past(pwm_irq))
    else $error("irq disagrees with masked read");
  chk_top_bits: assert property (pready |-> prdata[31:30] == 2'h0)
    else $error("unused bits read nonzero");
  chk_mask_quiet: assert property (en_off_s |=> !pwm_irq)
    else $error("irq with all enables off");
  chk_err_nodata: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error answer");
endmodule
`default_nettype wire

// ===== pwm_interrupt_status_clear_test.sv
/* Self-checking bench for the PWM interrupt block.
   Drives APB and event pins directly; no partner model. */
`default_nettype none
module pwm_interrupt_status_clear_test
  import pwmi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [29:0] ev; logic [2:0] flt; logic [31:0] en, raw, msk; logic irq;} pwmi_row_s;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pwm_irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [29:0] ev;
  logic [2:0] flt;
  int fails = 0;
  int checks = 0;
  // Event rows; fault rows rely on the level left by the row before
  pwmi_row_s rows [5] = '{
    '{30'h000001FF, 3'h0, 32'h000000AA, 32'h000001FF, 32'h000000AA, 1'b1},
    '{30'h3FFF8000, 3'h0, 32'h00000000, 32'h3FFF8000, 32'h00000000, 1'b0},
    '{30'h00000000, 3'h7, 32'h3FFFFFFF, 32'h00000E00, 32'h00000E00, 1'b1},
    '{30'h00000000, 3'h0, 32'h00001000, 32'h00007000, 32'h00001000, 1'b1},
    '{30'h00000000, 3'h0, 32'h00000000, 32'h00000000, 32'h00000000, 1'b0}};
  always #50 pclk = ~pclk;
  pwmi_irq_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_event(ev[29:27]), .one_shot_trip(ev[26:24]),
    .cycle_by_cycle_trip(ev[23:21]), .operator_compare_a_event(ev[17:15]),
    .operator_compare_b_event(ev[20:18]), .fault_event_0(flt[0]), .fault_event_1(flt[1]),
    .fault_event_2(flt[2]), .timer_period_event(ev[8:6]), .timer_zero_event(ev[5:3]),
    .timer_stop_event(ev[2:0]), .pwm_irq(pwm_irq));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic pulse(input logic [29:0] e, input logic [2:0] f);
    @(posedge pclk);
    ev <= e;
    flt <= f;
    @(posedge pclk);
    ev <= '0;
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, flt} = '0;
    pstrb = 4'hF;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("enable reset", PWMI_ENABLE_OFS, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, PWMI_ENABLE_OFS, rows[i].en);
      pulse(rows[i].ev, rows[i].flt);
      rd_chk("raw", PWMI_RAW_OFS, rows[i].raw);
      rd_chk("masked", PWMI_MASKED_OFS, rows[i].msk);
      chk("irq", {31'h0, rows[i].irq}, {31'h0, pwm_irq});
      apb(1'b1, PWMI_CLEAR_OFS, 32'hFFFFFFFF);
      rd_chk("cleared", PWMI_RAW_OFS, 32'h0);
    end
    rd_chk("clear read", PWMI_CLEAR_OFS, 32'h0);
    apb(1'b0, 12'h120, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    pulse(30'h38000007, 3'h0);
    apb(1'b1, PWMI_RAW_OFS, 32'h0);
    apb(1'b1, PWMI_CLEAR_OFS, 32'h0);
    rd_chk("zero clear", PWMI_RAW_OFS, 32'h38000007);
    pstrb <= 4'h1;
    apb(1'b1, PWMI_CLEAR_OFS, 32'hFFFFFFFF);
    rd_chk("lane clear", PWMI_RAW_OFS, 32'h38000000);
    pstrb <= 4'hF;
    apb(1'b1, PWMI_ENABLE_OFS, 32'h38000000);
    rd_chk("enable back", PWMI_ENABLE_OFS, 32'h38000000);
    rd_chk("capture mask", PWMI_MASKED_OFS, 32'h38000000);
    chk("irq on", 32'h1, {31'h0, pwm_irq});
    apb(1'b1, PWMI_ENABLE_OFS, 32'h0);
    rd_chk("masked off", PWMI_MASKED_OFS, 32'h0);
    chk("irq off", 32'h0, {31'h0, pwm_irq});
    // Event held across the clearing edge: the set must win
    ev <= 30'h00000001;
    apb(1'b1, PWMI_CLEAR_OFS, 32'hFFFFFFFF);
    rd_chk("set wins", PWMI_RAW_OFS, 32'h00000001);
    ev <= '0;
    apb(1'b1, PWMI_CLEAR_OFS, 32'hFFFFFFFF);
    rd_chk("held cleared", PWMI_RAW_OFS, 32'h0);
    // Reset in mid-run must drop flags, enables and the interrupt
    apb(1'b1, PWMI_ENABLE_OFS, 32'h3FFFFFFF);
    pulse(30'h00000007, 3'h0);
    rd_chk("masked before reset", PWMI_MASKED_OFS, 32'h00000007);
    chk("irq before reset", 32'h1, {31'h0, pwm_irq});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq in reset", 32'h0, {31'h0, pwm_irq});
    presetn <= 1'b1;
    rd_chk("raw after reset", PWMI_RAW_OFS, 32'h0);
    rd_chk("enable after reset", PWMI_ENABLE_OFS, 32'h0);
    results();
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    results();
  end
endmodule
bind pwmi_irq_ctrl pwmi_irq_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_irq(pwm_irq));
`default_nettype wire
